//--- rtl/bmiu_pkg.sv
// Overview of operation
// - Eight registers, word and byte access.
// - Byte move sets N, Z; clears V.
// - Byte moves never touch the carry flag.
// - Post-increment load: read, pointer plus one, length two.
// - Pre-decrement store: pointer minus one first, length two.
// - Sixteen-bit displacement load is four bytes long.
// - Twenty-four-bit displacement load is eight bytes long.
// - Sixteen-bit displacement store is four bytes long.
// - Twenty-four-bit displacement store is eight bytes long.
package bmiu_pkg;

  // Data path widths.
  localparam int ADDR_W = 32;
  localparam int NUM_REGS = 8;
  localparam int REG_W = 32;

  // Bit positions inside the condition flags register.
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Byte register code: bit 3 picks the low byte, bits 2..0 pick the register.
  localparam int BSEL_LOW = 3;

  // Page that eight-bit absolute addresses fall into.
  localparam logic [31:0] ABS8_BASE = 32'hFFFFFF00;

  // Instruction lengths in bytes.
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_D16 = 4'h4;
  localparam logic [3:0] LEN_D24 = 4'h8;
  localparam logic [3:0] LEN_ABS16 = 4'h4;
  localparam logic [3:0] LEN_ABS24 = 4'h6;

  // Byte move forms.
  typedef enum logic [3:0] {
    MV_IMM, MV_REG,
    LD_IND, LD_D16, LD_D24, LD_POST, LD_ABS8, LD_ABS16, LD_ABS24,
    ST_IND, ST_D16, ST_D24, ST_PRE, ST_ABS8, ST_ABS16, ST_ABS24
  } bmiu_mode_t;

  // One decoded byte move as handed over by the fetch stage.
  typedef struct packed {
    bmiu_mode_t mode;
    logic [3:0] dst;
    logic [3:0] src;
    logic [2:0] ptr;
    logic [23:0] ext;
  } bmiu_cmd_t;

  // Byte memory bus request.
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } bmiu_bus_t;

endpackage

//--- rtl/bmiu_gpr_file.sv
`timescale 1ns/1ps
// General register file with byte-lane writes and registered read ports.
module bmiu_gpr_file #(
  parameter int NUM = 8,
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Execution read port.
  input wire logic [$clog2(NUM)-1:0] rd_idx,
  output logic [W-1:0] rd_data,
  // Observation read port.
  input wire logic [$clog2(NUM)-1:0] obs_idx,
  output logic [W-1:0] obs_data,
  // Write port with one enable per byte lane.
  input wire logic we,
  input wire logic [$clog2(NUM)-1:0] widx,
  input wire logic [W/8-1:0] wbe,
  input wire logic [W-1:0] wdata
);

  // Each lane has storage of its own, so a byte write keeps its neighbours and
  // no two processes ever write one array.
  for (genvar b = 0; b < W / 8; b++) begin : g_lane
    logic [7:0] lane_mem [NUM]; // One byte of every register.
    // Cleared at reset: byte moves cannot reach the upper halves, so they must start known.
    always_ff @(posedge core_clk) begin
      if (rst) begin
        for (int r = 0; r < NUM; r++) begin
          lane_mem[r] <= 8'h00;
        end
      end else if (we && wbe[b]) begin
        lane_mem[widx] <= wdata[b*8 +: 8];
      end
    end
    // Read data come out of flip-flops, one cycle after the index.
    always_ff @(posedge core_clk) begin
      rd_data[b*8 +: 8] <= lane_mem[rd_idx];
      obs_data[b*8 +: 8] <= lane_mem[obs_idx];
    end
  end

endmodule

//--- rtl/bmiu_byte_move.sv
`timescale 1ns/1ps
// Executes byte moves between the general registers, immediates and memory.
module bmiu_byte_move (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Decoded instruction handshake.
  input wire logic cmd_valid,
  input wire bmiu_pkg::bmiu_cmd_t cmd,
  output logic cmd_ready,
  // Completion report.
  output logic done,
  output logic [3:0] instr_len,
  // Condition flags.
  output logic [7:0] condition_flags_register,
  // Byte memory bus.
  output bmiu_pkg::bmiu_bus_t bus,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // Register observation port.
  input wire logic [2:0] obs_idx,
  output logic [31:0] obs_data
);

  typedef enum logic [2:0] {S_IDLE, S_PTR, S_SRC, S_EXEC, S_BUS, S_PTRWB} bmiu_state_t;

  bmiu_state_t state; // Sequencer state.
  bmiu_pkg::bmiu_cmd_t cur; // Command being executed.
  logic [31:0] ptr_val; // Pointer register value read for this command.
  logic [2:0] rd_idx; // Register file read index.
  logic [31:0] rd_data; // Register file read data, one cycle late.
  logic rf_we; // Register file write strobe.
  logic [2:0] rf_widx; // Register file write index.
  logic [3:0] rf_wbe; // Register file byte enables.
  logic [31:0] rf_wdata; // Register file write data.
  logic [7:0] src_byte; // Source byte picked from the read word.
  logic [31:0] ea; // Effective address for memory forms.

  // Length of each form, shared by the completion report.
  function automatic logic [3:0] form_len(input bmiu_pkg::bmiu_mode_t m);
    case (m)
      bmiu_pkg::LD_D16, bmiu_pkg::ST_D16: form_len = bmiu_pkg::LEN_D16;
      bmiu_pkg::LD_D24, bmiu_pkg::ST_D24: form_len = bmiu_pkg::LEN_D24;
      bmiu_pkg::LD_ABS16, bmiu_pkg::ST_ABS16: form_len = bmiu_pkg::LEN_ABS16;
      bmiu_pkg::LD_ABS24, bmiu_pkg::ST_ABS24: form_len = bmiu_pkg::LEN_ABS24;
      // Post-increment and pre-decrement are short forms.
      default: form_len = bmiu_pkg::LEN_SHORT;
    endcase
  endfunction

  // Byte lane mask of a byte register code: high byte is lane 1, low byte lane 0.
  function automatic logic [3:0] lane_mask(input logic [3:0] code);
    lane_mask = code[bmiu_pkg::BSEL_LOW] ? 4'h1 : 4'h2;
  endfunction

  // Picks a byte register out of its containing word.
  function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [3:0] code);
    get_byte = code[bmiu_pkg::BSEL_LOW] ? w[7:0] : w[15:8];
  endfunction

  // True for forms that read memory into a register.
  function automatic logic is_load(input bmiu_pkg::bmiu_mode_t m);
    is_load = (m >= bmiu_pkg::LD_IND) && (m <= bmiu_pkg::LD_ABS24);
  endfunction

  // The shared register file; its reads are registered.
  bmiu_gpr_file #(.NUM(bmiu_pkg::NUM_REGS), .W(bmiu_pkg::REG_W)) u_gpr (
    .core_clk(core_clk),
    .rst(rst),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .obs_idx(obs_idx),
    .obs_data(obs_data),
    .we(rf_we),
    .widx(rf_widx),
    .wbe(rf_wbe),
    .wdata(rf_wdata)
  );

  // The source byte comes from the word read for the source register.
  assign src_byte = get_byte(rd_data, cur.src);

  // Effective address; displacements are sign-extended, the 24-bit absolute form zero-extended.
  always_comb begin
    case (cur.mode)
      bmiu_pkg::LD_D16, bmiu_pkg::ST_D16:
        ea = ptr_val + {{16{cur.ext[15]}}, cur.ext[15:0]};
      bmiu_pkg::LD_D24, bmiu_pkg::ST_D24:
        ea = ptr_val + {{8{cur.ext[23]}}, cur.ext};
      bmiu_pkg::ST_PRE: ea = ptr_val - 32'h00000001;
      bmiu_pkg::LD_ABS8, bmiu_pkg::ST_ABS8: ea = bmiu_pkg::ABS8_BASE | {24'h000000, cur.ext[7:0]};
      bmiu_pkg::LD_ABS16, bmiu_pkg::ST_ABS16:
        ea = {{16{cur.ext[15]}}, cur.ext[15:0]};
      bmiu_pkg::LD_ABS24, bmiu_pkg::ST_ABS24: ea = {8'h00, cur.ext};
      default: ea = ptr_val;
    endcase
  end

  // Sequencer: read pointer, read source, then execute and write back.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= S_IDLE;
      cur <= '0;
      rd_idx <= 3'h0;
      ptr_val <= 32'h00000000;
    end else begin
      case (state)
        S_IDLE: begin
          // A command is taken only while idle, so the ready flop is high.
          if (cmd_valid && cmd_ready) begin
            cur <= cmd;
            rd_idx <= cmd.ptr;
            state <= S_PTR;
          end
        end
        S_PTR: begin
          // The register file now latches the pointer; ask for the source next.
          rd_idx <= cur.src[2:0];
          state <= S_SRC;
        end
        S_SRC: begin
          ptr_val <= rd_data;
          state <= S_EXEC;
        end
        S_EXEC: begin
          // Register and immediate forms finish here; the rest go to the bus.
          if (cur.mode == bmiu_pkg::MV_IMM || cur.mode == bmiu_pkg::MV_REG) begin
            state <= S_IDLE;
          end else begin
            state <= S_BUS;
          end
        end
        S_BUS: begin
          if (mem_ack) begin
            state <= (cur.mode == bmiu_pkg::LD_POST) ? S_PTRWB : S_IDLE;
          end
        end
        S_PTRWB: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Ready is high only in the idle state, rising in the same cycle as the last write is posted.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_ready <= 1'b1;
    end else if (state == S_IDLE && cmd_valid && cmd_ready) begin
      cmd_ready <= 1'b0;
    end else if ((state == S_EXEC && (cur.mode == bmiu_pkg::MV_IMM ||
                  cur.mode == bmiu_pkg::MV_REG)) ||
                 (state == S_BUS && mem_ack && cur.mode != bmiu_pkg::LD_POST) ||
                 state == S_PTRWB) begin
      cmd_ready <= 1'b1;
    end
  end

  // Memory bus: one byte request held until acknowledged.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus <= '0;
    end else if (state == S_EXEC && cur.mode != bmiu_pkg::MV_IMM &&
                 cur.mode != bmiu_pkg::MV_REG) begin
      bus.req <= 1'b1;
      bus.we <= !is_load(cur.mode);
      bus.addr <= ea;
      bus.wdata <= src_byte;
    end else if (state == S_BUS && mem_ack) begin
      bus.req <= 1'b0;
      bus.we <= 1'b0;
    end
  end

  // Register file writes: destination byte, incremented or decremented pointer.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rf_we <= 1'b0;
      rf_widx <= 3'h0;
      rf_wbe <= 4'h0;
      rf_wdata <= 32'h00000000;
    end else begin
      rf_we <= 1'b0;
      if (state == S_EXEC && cur.mode == bmiu_pkg::MV_IMM) begin
        rf_we <= 1'b1;
        rf_widx <= cur.dst[2:0];
        rf_wbe <= lane_mask(cur.dst);
        rf_wdata <= {4{cur.ext[7:0]}};
      end else if (state == S_EXEC && cur.mode == bmiu_pkg::MV_REG) begin
        rf_we <= 1'b1;
        rf_widx <= cur.dst[2:0];
        rf_wbe <= lane_mask(cur.dst);
        rf_wdata <= {4{src_byte}};
      end else if (state == S_EXEC && cur.mode == bmiu_pkg::ST_PRE) begin
        // The pointer is lowered in the same cycle the store starts.
        rf_we <= 1'b1;
        rf_widx <= cur.ptr;
        rf_wbe <= 4'hF;
        rf_wdata <= ea;
      end else if (state == S_BUS && mem_ack && is_load(cur.mode)) begin
        rf_we <= 1'b1;
        rf_widx <= cur.dst[2:0];
        rf_wbe <= lane_mask(cur.dst);
        rf_wdata <= {4{mem_rdata}};
      end else if (state == S_PTRWB) begin
        // Written after the loaded byte, so a pointer that is also the target wins.
        rf_we <= 1'b1;
        rf_widx <= cur.ptr;
        rf_wbe <= 4'hF;
        rf_wdata <= ptr_val + 32'h00000001;
      end
    end
  end

  // Flags follow the moved byte; carry and the upper bits are left alone.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      condition_flags_register <= bmiu_pkg::FLAGS_RESET;
    end else if (state == S_EXEC && cur.mode == bmiu_pkg::MV_IMM) begin
      condition_flags_register[bmiu_pkg::FLAG_N] <= cur.ext[7];
      condition_flags_register[bmiu_pkg::FLAG_Z] <= (cur.ext[7:0] == 8'h00);
      condition_flags_register[bmiu_pkg::FLAG_V] <= 1'b0;
    end else if (state == S_EXEC && !is_load(cur.mode)) begin
      // Register moves and stores take the flags from the source byte.
      condition_flags_register[bmiu_pkg::FLAG_N] <= src_byte[7];
      condition_flags_register[bmiu_pkg::FLAG_Z] <= (src_byte == 8'h00);
      condition_flags_register[bmiu_pkg::FLAG_V] <= 1'b0;
    end else if (state == S_BUS && mem_ack && is_load(cur.mode)) begin
      condition_flags_register[bmiu_pkg::FLAG_N] <= mem_rdata[7];
      condition_flags_register[bmiu_pkg::FLAG_Z] <= (mem_rdata == 8'h00);
      condition_flags_register[bmiu_pkg::FLAG_V] <= 1'b0;
    end
  end

  // Completion pulse with the length of the finished instruction.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done <= 1'b0;
      instr_len <= 4'h0;
    end else begin
      done <= 1'b0;
      if ((state == S_EXEC && (cur.mode == bmiu_pkg::MV_IMM ||
           cur.mode == bmiu_pkg::MV_REG)) ||
          (state == S_BUS && mem_ack && cur.mode != bmiu_pkg::LD_POST) ||
          state == S_PTRWB) begin
        done <= 1'b1;
        instr_len <= form_len(cur.mode);
      end
    end
  end

endmodule

//--- test/bmiu_byte_move_chk.sv
`timescale 1ns/1ps
// Watches the byte move unit at its ports; the mode and the moved byte are latched here.
module bmiu_byte_move_chk (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Command side.
  input wire logic cmd_valid,
  input wire bmiu_pkg::bmiu_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic [3:0] instr_len,
  input wire logic [7:0] condition_flags_register,
  // Memory side.
  input wire bmiu_pkg::bmiu_bus_t bus,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  bmiu_pkg::bmiu_mode_t mode_q; // Mode of the command in flight.
  logic [7:0] byte_q; // Byte that last crossed the bus.
  logic mem_q; // High when the command in flight uses the bus.
  // Remember the taken mode so that its completion can be judged.
  always_ff @(posedge core_clk) begin
    if (cmd_valid && cmd_ready) begin
      mode_q <= cmd.mode;
    end
  end
  // Remember the byte at the ack, since the flags must follow it.
  always_ff @(posedge core_clk) begin
    if (mem_ack && bus.req) begin
      byte_q <= bus.we ? bus.wdata : mem_rdata;
    end
  end
  assign mem_q = mode_q > bmiu_pkg::MV_REG;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_carry; $stable(condition_flags_register[0]); endproperty
  a_carry: assert property (p_carry) else $error("carry flag moved");
  property p_vclr; done |-> !condition_flags_register[1]; endproperty
  a_vclr: assert property (p_vclr) else $error("overflow flag set");
  property p_nz; done && mem_q |-> condition_flags_register[3] == byte_q[7] &&
    condition_flags_register[2] == (byte_q == 8'h00); endproperty
  a_nz: assert property (p_nz) else $error("N or Z wrong");
  property p_short; done && (mode_q == bmiu_pkg::LD_POST || mode_q == bmiu_pkg::ST_PRE)
    |-> instr_len == 4'h2; endproperty
  a_short: assert property (p_short) else $error("short length wrong");
  property p_d16; done && (mode_q == bmiu_pkg::LD_D16 || mode_q == bmiu_pkg::ST_D16)
    |-> instr_len == 4'h4; endproperty
  a_d16: assert property (p_d16) else $error("d16 length wrong");
  property p_d24; done && (mode_q == bmiu_pkg::LD_D24 || mode_q == bmiu_pkg::ST_D24)
    |-> instr_len == 4'h8; endproperty
  a_d24: assert property (p_d24) else $error("d24 length wrong");
  property p_ack; mem_ack && bus.req && mode_q != bmiu_pkg::LD_POST |=> done; endproperty
  a_ack: assert property (p_ack) else $error("no done after ack");
  property p_post; mem_ack && bus.req && mode_q == bmiu_pkg::LD_POST |=> !done ##1 done;
  endproperty
  a_post: assert property (p_post) else $error("post load done late");
  property p_hold; bus.req && !mem_ack |=> bus.req && $stable(bus); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_we; $rose(bus.req) |-> bus.we == (mode_q >= bmiu_pkg::ST_IND); endproperty
  a_we: assert property (p_we) else $error("write enable wrong");
  c_post: cover property (done && mode_q == bmiu_pkg::LD_POST);
  c_pre: cover property (done && mode_q == bmiu_pkg::ST_PRE);
  c_stall: cover property (bus.req && !mem_ack [*3]);
endmodule
bind bmiu_byte_move bmiu_byte_move_chk u_chk (.core_clk(core_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
  .instr_len(instr_len), .condition_flags_register(condition_flags_register), .bus(bus),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata));

//--- test/bmiu_mem_model.sv
`timescale 1ns/1ps
// Byte memory: acks after a set stall and records the request that it served.
module bmiu_mem_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Request and reply.
  input wire bmiu_pkg::bmiu_bus_t bus,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // Bench knobs and record.
  input wire logic [3:0] stall,
  input wire logic [7:0] rd_byte,
  output bmiu_pkg::bmiu_bus_t seen
);
  logic [3:0] wait_cnt; // Cycles the request has waited.
  logic fire; // This edge answers.
  assign fire = bus.req && !mem_ack && wait_cnt == stall;
  // Count wait cycles, then pulse ack once.
  always_ff @(posedge core_clk) begin
    if (rst || !bus.req || mem_ack) begin
      wait_cnt <= 4'h0;
      mem_ack <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      mem_ack <= fire;
    end
  end
  // Data is valid with ack only; otherwise it toggles so a late sample cannot pass.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_rdata <= 8'h5A;
    end else begin
      mem_rdata <= fire ? rd_byte : ~mem_rdata;
    end
  end
  // Keep the served request for the bench.
  always_ff @(posedge core_clk) begin
    if (fire) begin
      seen <= bus;
    end
  end
endmodule

//--- test/byte_move_instruction_unit_test.sv
`timescale 1ns/1ps
// Self-checking bench. Registers clear at reset, so the pointer's upper half stays
// zero and every bus address can be compared.
module byte_move_instruction_unit_test;
  logic core_clk, rst, cmd_valid, cmd_ready, done, mem_ack;
  bmiu_pkg::bmiu_cmd_t cmd;
  bmiu_pkg::bmiu_bus_t bus, seen;
  logic [3:0] instr_len, stall;
  logic [7:0] flags, mem_rdata, rd_byte;
  logic [2:0] obs_idx;
  logic [31:0] obs_data, val;
  logic [3:0] lens [7] = '{4'h2, 4'h4, 4'h8, 4'h2, 4'h2, 4'h4, 4'h6};
  // Expected addresses with the pointer at 1234 for loads and 1235 for stores.
  logic [31:0] ld_adr [7] = '{32'h00001234, 32'h00001244, 32'h00001244, 32'h00001234,
    bmiu_pkg::ABS8_BASE | 32'h00000010, 32'h00000010, 32'h00000010};
  logic [31:0] st_adr [7] = '{32'h00001235, 32'h00001245, 32'h00001245, 32'h00001234,
    bmiu_pkg::ABS8_BASE | 32'h00000010, 32'h00000010, 32'h00000010};
  int fails, checks;
  bmiu_byte_move DUT (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .done(done), .instr_len(instr_len),
    .condition_flags_register(flags), .bus(bus), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .obs_idx(obs_idx), .obs_data(obs_data));
  bmiu_mem_model mem (.core_clk(core_clk), .rst(rst), .bus(bus), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .stall(stall), .rd_byte(rd_byte), .seen(seen));
  // Clock of 4 ns.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Compare one value and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Offer a command until taken, then wait for done under a bound.
  task automatic run(input bmiu_pkg::bmiu_mode_t m, input logic [3:0] d,
      input logic [3:0] s, input logic [23:0] x);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    cmd = '{m, d, s, 3'h6, x};
    cmd_valid = 1'b1;
    // Ready only moves on an edge, so a high level seen here is taken at the next one.
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (done !== 1'b1) chk(done, 1'b1);
  endtask
  // Read a register through the observation port.
  task automatic rd(input logic [2:0] i);
    obs_idx = i;
    repeat (2) @(posedge core_clk);
    #1;
    val = obs_data;
  endtask
  // Immediate moves into byte lanes.
  task automatic t_imm;
    run(bmiu_pkg::MV_IMM, 4'h9, 4'h0, 24'h000080);
    chk(flags, 8'h08);
    run(bmiu_pkg::MV_IMM, 4'h1, 4'h0, 24'h000000);
    chk(flags, 8'h04);
    rd(3'h1);
    chk(val[15:0], 16'h0080);
    run(bmiu_pkg::MV_IMM, 4'h9, 4'h0, 24'h00007F);
    rd(3'h1);
    chk(val[15:0], 16'h007F);
    $display("test imm done");
  endtask
  // Register to register byte move.
  task automatic t_reg;
    run(bmiu_pkg::MV_REG, 4'hB, 4'h9, 24'h000000);
    chk(flags, 8'h00);
    rd(3'h3);
    chk(val[7:0], 8'h7F);
    $display("test reg done");
  endtask
  // Every load form; odd ones stall and fetch zero.
  task automatic t_load;
    logic [7:0] b;
    run(bmiu_pkg::MV_IMM, 4'h4, 4'h0, 24'h00005A);
    run(bmiu_pkg::MV_IMM, 4'h6, 4'h0, 24'h000012);
    run(bmiu_pkg::MV_IMM, 4'hE, 4'h0, 24'h000034);
    for (int i = 0; i < 7; i++) begin
      b = i[0] ? 8'h00 : 8'hC3;
      stall = i[0] ? 4'h3 : 4'h0;
      rd_byte = b;
      run(bmiu_pkg::bmiu_mode_t'(i + 2), 4'hC, 4'h0, 24'h000010);
      chk(instr_len, lens[i]);
      chk(flags, {4'h0, b[7], b == 8'h00, 2'b00});
      chk(seen.we, 1'b0);
      chk(seen.addr, ld_adr[i]);
      rd(3'h4);
      chk(val[15:0], {8'h5A, b});
    end
    rd(3'h6);
    chk(val, 32'h00001235);
    $display("test load done");
  endtask
  // Every store form; odd ones stall and store zero.
  task automatic t_store;
    logic [7:0] b;
    for (int i = 0; i < 7; i++) begin
      b = i[0] ? 8'h00 : 8'h7F;
      stall = i[0] ? 4'h3 : 4'h0;
      run(bmiu_pkg::bmiu_mode_t'(i + 9), 4'h0, i[0] ? 4'h1 : 4'hB, 24'h000010);
      chk(instr_len, lens[i]);
      chk(flags, {4'h0, b[7], b == 8'h00, 2'b00});
      chk({seen.we, seen.wdata}, {1'b1, b});
      chk(seen.addr, st_adr[i]);
    end
    rd(3'h6);
    chk(val, 32'h00001234);
    $display("test store done");
  endtask
  // Reset in mid-run: outputs and registers go back to their reset values.
  task automatic t_rst;
    @(posedge core_clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk({cmd_ready, done, instr_len, flags, bus.req}, {1'b1, 1'b0, 4'h0, 8'h00, 1'b0});
    rd(3'h6);
    chk(val, 32'h00000000);
    run(bmiu_pkg::MV_IMM, 4'hE, 4'h0, 24'h0000FF);
    chk(flags, 8'h08);
    rd(3'h6);
    chk(val, 32'h000000FF);
    $display("test reset done");
  endtask
  // Print the counts and the verdict, then stop.
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    obs_idx = 3'h0;
    stall = 4'h0;
    rd_byte = 8'h00;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_imm;
    t_reg;
    t_load;
    t_store;
    t_rst;
    finish_test;
  end
  // The tests need about 770 ns; this cuts a hang short.
  initial begin
    #8000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end
endmodule
